// ==== hdl/dop_pkg.sv ====
// Constants and types of the four-channel output register bank
package dop_pkg;
	localparam int NCH = 4;
	// Point tables
	localparam logic [1:0] TBL_COIL = 2'h0;
	localparam logic [1:0] TBL_DISC = 2'h1;
	localparam logic [1:0] TBL_HOLD = 2'h2;
	localparam logic [1:0] TBL_INPT = 2'h3;
	// Start addresses
	localparam logic [15:0] ADR_OUT_STATE  = 16'h0000;
	localparam logic [15:0] ADR_PULSE_RUN  = 16'h0010;
	localparam logic [15:0] ADR_PACKED_OUT = 16'h0020;
	localparam logic [15:0] ADR_PULSE_CNT  = 16'h0024;
	localparam logic [15:0] ADR_HIGH_TIME  = 16'h0034;
	localparam logic [15:0] ADR_LOW_TIME   = 16'h0044;
	localparam logic [15:0] ADR_PEER_LINK  = 16'h1000;
	localparam logic [15:0] ADR_SAFE_FLAG  = 16'h1010;
	localparam logic [15:0] ADR_ALARM_CLR  = 16'h1030;
	localparam logic [15:0] ADR_UPTIME     = 16'h139C;
	localparam logic [15:0] ADR_HW_ADDR    = 16'h13A0;
	localparam logic [15:0] ADR_NET_ADDR   = 16'h13A3;
	localparam logic [15:0] ADR_FW_REL     = 16'h13A5;
	localparam logic [15:0] ADR_FW_BUILD   = 16'h13A7;
	localparam logic [15:0] ADR_LABEL      = 16'h13B0;
	localparam int          LABEL_WORDS    = 30;
	// Reset values
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [15:0] RST_TIME  = 16'h0001;
	// Timing
	localparam int CLK_MHZ      = 125;
	localparam int TICK_US      = 1000;
	localparam int MS_CYC       = CLK_MHZ * TICK_US;
	localparam int MS_PER_SEC   = 1000;

	typedef struct packed {
		logic [1:0]  table_sel;
		logic [15:0] addr;
		logic        write;
		logic [15:0] wdata;
	} dop_req_t;

	typedef struct packed {
		logic [15:0] high_time;
		logic [15:0] low_time;
		logic [15:0] count;
	} dop_pulse_cfg_t;
endpackage

// ==== hdl/dop_pulse.sv ====
// One channel pulse train generator
`timescale 1ns/1ps
module dop_pulse
	import dop_pkg::*;
(
	// Clock and reset
	input  wire logic           i_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_ce,
	// Control
	input  wire logic           i_run,
	input  wire logic           i_tick,
	input  wire dop_pulse_cfg_t i_cfg,
	// Status
	output logic                o_level,
	output logic                o_done
);
	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_HIGH, ST_LOW} dop_pst_t;
	dop_pst_t    st;
	logic [15:0] cnt;
	logic [15:0] num;
	logic        run_q;
	logic        hi_end;
	logic        lo_end;

	assign hi_end = i_tick && (cnt + 16'h0001 >= i_cfg.high_time);
	assign lo_end = i_tick && (cnt + 16'h0001 >= i_cfg.low_time);
	// Done only fires once the programmed count of pulses has elapsed
	assign o_done = (st == ST_LOW) && lo_end && (i_cfg.count != 16'h0000)
		&& (num >= i_cfg.count);
	assign o_level = (st == ST_HIGH);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_q <= 1'b0;
		end else if (i_ce) begin
			run_q <= i_run;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st  <= ST_IDLE;
			cnt <= 16'h0000;
			num <= 16'h0000;
		end else if (i_ce) begin
			unique case (st)
				ST_IDLE: begin
					// Edge start, so the cycle that clears run cannot restart
					if (i_run && !run_q) begin
						st <= ST_ARM;
					end
				end
				// Start on a tick so the first high is whole ms,
				// at the cost of up to one ms of start latency
				ST_ARM: begin
					if (!i_run) begin
						st <= ST_IDLE;
					end else if (i_tick) begin
						st  <= ST_HIGH;
						cnt <= 16'h0000;
						num <= 16'h0000;
					end
				end
				ST_HIGH: begin
					if (!i_run) begin
						st <= ST_IDLE;
					end else if (hi_end) begin
						st  <= ST_LOW;
						cnt <= 16'h0000;
						num <= num + 16'h0001;
					end else if (i_tick) begin
						cnt <= cnt + 16'h0001;
					end
				end
				ST_LOW: begin
					if (!i_run || o_done) begin
						st <= ST_IDLE;
					end else if (lo_end) begin
						st  <= ST_HIGH;
						cnt <= 16'h0000;
					end else if (i_tick) begin
						cnt <= cnt + 16'h0001;
					end
				end
			endcase
		end
	end

	a_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_ce && !i_run) |=> (st == ST_IDLE))
		else $error("channel kept pulsing after run cleared");
	a_done_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_ce && o_done) |=> (st == ST_IDLE) && !o_level)
		else $error("channel kept pulsing after count reached");
	c_pulse_done: cover property (@(posedge i_clk) disable iff (!i_rstn)
		o_done);
endmodule

// ==== hdl/dop_regs.sv ====
// Register bank and pulse control of the four-channel output unit
`timescale 1ns/1ps
module dop_regs
	import dop_pkg::*;
#(
	parameter int          MS_CYCLES = MS_CYC,
	// Arbitrary neutral identity values
	parameter logic [47:0] HW_ADDR   = 48'h02_00_00_00_00_01,
	parameter logic [31:0] NET_ADDR  = 32'hC0_A8_00_02,
	parameter logic [23:0] FW_REL    = 24'h01_00_00,
	parameter logic [31:0] FW_BUILD  = 32'h0000_0001,
	parameter logic [16*LABEL_WORDS-1:0] LABEL = {8'h55, 8'h4E,
		{(16*LABEL_WORDS-16){1'b0}}}
) (
	// Clock, reset, enable
	input  wire logic           I_CORE_CLK,
	input  wire logic           I_RESETN,
	input  wire logic           I_CORE_CE,
	// Point access request
	input  wire logic           I_REQ_VALID,
	input  wire dop_req_t       I_REQ,
	// Point access answer
	output logic                O_RSP_VALID,
	output logic [15:0]         O_RSP_DATA,
	output logic                O_RSP_ERR,
	// Status pins
	input  wire logic [NCH-1:0] I_PEER_LINK,
	input  wire logic [NCH-1:0] I_SAFE_MODE,
	input  wire logic           I_WDOG_TRIP,
	// Outputs
	output logic                O_WDOG_ALARM,
	output logic [NCH-1:0]      O_CH_OUT
);
	logic [NCH-1:0]  out_state;
	logic [NCH-1:0]  pulse_run;
	logic [15:0]     pulse_cnt [NCH];
	logic [15:0]     high_time [NCH];
	logic [15:0]     low_time  [NCH];
	logic [NCH-1:0]  lvl;
	logic [NCH-1:0]  done;
	logic [2*NCH:0]  sync_a;
	logic [2*NCH:0]  sync_b;
	logic            trip_q;
	logic            alarm;
	logic [16:0]     ms_div;
	logic            tick;
	logic [9:0]      ms_in_sec;
	logic [31:0]     uptime;
	logic [15:0]     next_data;
	logic            next_err;
	logic [15:0]     off;
	logic            wr;

	assign wr = I_REQ_VALID && I_REQ.write;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sync_a <= '0;
			sync_b <= '0;
		end else if (I_CORE_CE) begin
			sync_a <= {I_WDOG_TRIP, I_SAFE_MODE, I_PEER_LINK};
			sync_b <= sync_a;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time base
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ms_div <= 17'h00000;
		end else if (I_CORE_CE) begin
			ms_div <= tick ? 17'h00000 : ms_div + 17'h00001;
		end
	end
	assign tick = (ms_div == 17'(MS_CYCLES - 1));

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ms_in_sec <= 10'h000;
			uptime    <= 32'h0000_0000;
		end else if (I_CORE_CE && tick) begin
			if (ms_in_sec == 10'(MS_PER_SEC - 1)) begin
				ms_in_sec <= 10'h000;
				uptime    <= uptime + 32'h0000_0001;
			end else begin
				ms_in_sec <= ms_in_sec + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog alarm
	// Clear on write of one
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			trip_q <= 1'b0;
			alarm  <= 1'b0;
		end else if (I_CORE_CE) begin
			trip_q <= sync_b[2*NCH];
			// A new trip wins over a clear in the same cycle
			if (sync_b[2*NCH] && !trip_q) begin
				alarm <= 1'b1;
			end else if (wr && I_REQ.table_sel == TBL_COIL
				&& I_REQ.addr == ADR_ALARM_CLR && I_REQ.wdata[0]) begin
				alarm <= 1'b0;
			end
		end
	end
	assign O_WDOG_ALARM = alarm;

	////////////////////////////////////////////////////////////////////////
	// Writable points
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			out_state <= '0;
		end else if (I_CORE_CE && wr) begin
			if (I_REQ.table_sel == TBL_COIL && I_REQ.addr < 16'(NCH)) begin
				out_state[I_REQ.addr[1:0]] <= I_REQ.wdata[0];
			end
			if (I_REQ.table_sel == TBL_HOLD && I_REQ.addr == ADR_PACKED_OUT)
			begin
				out_state <= I_REQ.wdata[NCH-1:0];
			end
		end
	end

	// Run coils, a client start in the done cycle keeps the coil set but the train stays stopped
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pulse_run <= '0;
		end else if (I_CORE_CE) begin
			for (int c = 0; c < NCH; c++) begin
				if (wr && I_REQ.table_sel == TBL_COIL
					&& I_REQ.addr == ADR_PULSE_RUN + 16'(c)) begin
					pulse_run[c] <= I_REQ.wdata[0];
				end else if (done[c]) begin
					pulse_run[c] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			for (int c = 0; c < NCH; c++) begin
				pulse_cnt[c] <= RST_WORD;
				high_time[c] <= RST_TIME;
				low_time[c]  <= RST_TIME;
			end
		end else if (I_CORE_CE && wr && I_REQ.table_sel == TBL_HOLD) begin
			for (int c = 0; c < NCH; c++) begin
				if (I_REQ.addr == ADR_PULSE_CNT + 16'(c)) begin
					pulse_cnt[c] <= I_REQ.wdata;
				end
				if (I_REQ.addr == ADR_HIGH_TIME + 16'(c)) begin
					high_time[c] <= I_REQ.wdata;
				end
				if (I_REQ.addr == ADR_LOW_TIME + 16'(c)) begin
					low_time[c] <= I_REQ.wdata;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pulse generators
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		dop_pulse u_pulse (
			.i_clk   (I_CORE_CLK),
			.i_rstn  (I_RESETN),
			.i_ce    (I_CORE_CE),
			.i_run   (pulse_run[c]),
			.i_tick  (tick),
			.i_cfg   ({high_time[c], low_time[c], pulse_cnt[c]}),
			.o_level (lvl[c]),
			.o_done  (done[c])
		);
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_CH_OUT <= '0;
		end else if (I_CORE_CE) begin
			O_CH_OUT <= (pulse_run & lvl) | (~pulse_run & out_state);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read decode
	always_comb begin
		next_data = 16'h0000;
		next_err  = 1'b0;
		off       = 16'h0000;
		unique case (I_REQ.table_sel)
			TBL_COIL: begin
				if (I_REQ.addr < 16'(NCH)) begin
					next_data = {15'h0000, out_state[I_REQ.addr[1:0]]};
				end else if (I_REQ.addr - ADR_PULSE_RUN < 16'(NCH)) begin
					off       = I_REQ.addr - ADR_PULSE_RUN;
					next_data = {15'h0000, pulse_run[off[1:0]]};
				end else if (I_REQ.addr == ADR_ALARM_CLR) begin
					next_data = {15'h0000, alarm};
				end else begin
					next_err = 1'b1;
				end
			end
			TBL_DISC: begin
				next_err = I_REQ.write;
				if (I_REQ.addr - ADR_PEER_LINK < 16'(NCH)) begin
					off       = I_REQ.addr - ADR_PEER_LINK;
					next_data = {15'h0000, sync_b[off[1:0]]};
				end else if (I_REQ.addr - ADR_SAFE_FLAG < 16'(NCH)) begin
					off       = I_REQ.addr - ADR_SAFE_FLAG;
					next_data = {15'h0000, sync_b[NCH + 32'(off[1:0])]};
				end else begin
					next_err = 1'b1;
				end
			end
			TBL_HOLD: begin
				if (I_REQ.addr == ADR_PACKED_OUT) begin
					next_data = {12'h000, out_state};
				end else if (I_REQ.addr - ADR_PULSE_CNT < 16'(NCH)) begin
					off       = I_REQ.addr - ADR_PULSE_CNT;
					next_data = pulse_cnt[off[1:0]];
				end else if (I_REQ.addr - ADR_HIGH_TIME < 16'(NCH)) begin
					off       = I_REQ.addr - ADR_HIGH_TIME;
					next_data = high_time[off[1:0]];
				end else if (I_REQ.addr - ADR_LOW_TIME < 16'(NCH)) begin
					off       = I_REQ.addr - ADR_LOW_TIME;
					next_data = low_time[off[1:0]];
				end else begin
					next_err = 1'b1;
				end
			end
			TBL_INPT: begin
				next_err = I_REQ.write;
				off      = I_REQ.addr - ADR_LABEL;
				unique case (I_REQ.addr)
					ADR_UPTIME:              next_data = uptime[31:16];
					ADR_UPTIME + 16'h0001:   next_data = uptime[15:0];
					ADR_HW_ADDR:             next_data = HW_ADDR[47:32];
					ADR_HW_ADDR + 16'h0001:  next_data = HW_ADDR[31:16];
					ADR_HW_ADDR + 16'h0002:  next_data = HW_ADDR[15:0];
					ADR_NET_ADDR:            next_data = NET_ADDR[31:16];
					ADR_NET_ADDR + 16'h0001: next_data = NET_ADDR[15:0];
					ADR_FW_REL:              next_data = FW_REL[23:8];
					ADR_FW_REL + 16'h0001:   next_data = {FW_REL[7:0], 8'h00};
					ADR_FW_BUILD:            next_data = FW_BUILD[31:16];
					ADR_FW_BUILD + 16'h0001: next_data = FW_BUILD[15:0];
					default: begin
						if (off < 16'(LABEL_WORDS)) begin
							next_data = LABEL[16*LABEL_WORDS-1
								- 16*32'(off) -: 16];
						end else begin
							next_err = 1'b1;
						end
					end
				endcase
			end
		endcase
	end

	// Answer one cycle after the request
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_RSP_VALID <= 1'b0;
			O_RSP_DATA  <= 16'h0000;
			O_RSP_ERR   <= 1'b0;
		end else if (I_CORE_CE) begin
			O_RSP_VALID <= I_REQ_VALID;
			if (I_REQ_VALID) begin
				O_RSP_DATA <= I_REQ.write ? 16'h0000 : next_data;
				O_RSP_ERR  <= next_err;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_coil_write: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && wr && I_REQ.table_sel == TBL_COIL && I_REQ.addr == 16'h0)
		|=> out_state[0] == $past(I_REQ.wdata[0]))
		else $error("output coil write not stored");
	a_packed_read: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && I_REQ_VALID && !I_REQ.write
		&& I_REQ.table_sel == TBL_HOLD && I_REQ.addr == ADR_PACKED_OUT)
		|=> O_RSP_DATA == {12'h000, $past(out_state)})
		else $error("packed word does not match output states");
	a_run_start: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && wr && I_REQ.table_sel == TBL_COIL
		&& I_REQ.addr == ADR_PULSE_RUN && I_REQ.wdata[0])
		|=> pulse_run[0])
		else $error("run coil write did not start channel");
	a_high_store: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && wr && I_REQ.table_sel == TBL_HOLD
		&& I_REQ.addr == ADR_HIGH_TIME)
		|=> high_time[0] == $past(I_REQ.wdata))
		else $error("high time not stored");
	a_low_store: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && wr && I_REQ.table_sel == TBL_HOLD
		&& I_REQ.addr == ADR_LOW_TIME)
		|=> low_time[0] == $past(I_REQ.wdata))
		else $error("low time not stored");
	a_alarm_clear: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && wr && I_REQ.table_sel == TBL_COIL
		&& I_REQ.addr == ADR_ALARM_CLR && I_REQ.wdata[0]
		&& !(sync_b[2*NCH] && !trip_q)) |=> !alarm)
		else $error("alarm survived its clear");
	a_uptime_step: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && tick && ms_in_sec == 10'(MS_PER_SEC - 1))
		|=> uptime == $past(uptime) + 32'h0000_0001)
		else $error("uptime did not advance at second end");
	a_ro_refused: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && wr && I_REQ.table_sel[0]) |=> O_RSP_ERR)
		else $error("write to status point not refused");
	a_link_read: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RESETN)
		(I_CORE_CE && I_REQ_VALID && !I_REQ.write
		&& I_REQ.table_sel == TBL_DISC && I_REQ.addr == ADR_PEER_LINK)
		|=> O_RSP_DATA == {15'h0000, $past(sync_b[0])})
		else $error("peer link bit misreported");
	c_alarm_set: cover property (@(posedge I_CORE_CLK) alarm);
	c_label_read: cover property (@(posedge I_CORE_CLK) I_REQ_VALID
		&& I_REQ.table_sel == TBL_INPT && I_REQ.addr == ADR_LABEL);
	c_train: cover property (@(posedge I_CORE_CLK) pulse_run[0] && lvl[0]);
endmodule

// ==== verif/dop_client.sv ====
// Point access client model facing the register bank
`timescale 1ns/1ps
module dop_client
	import dop_pkg::*;
(
	// Clock
	input  wire logic        i_clk,
	// Request
	output logic             o_req_valid,
	output dop_req_t         o_req,
	// Answer
	input  wire logic        i_rsp_valid,
	input  wire logic [15:0] i_rsp_data,
	input  wire logic        i_rsp_err
);
	initial begin
		o_req_valid = 1'b0;
		o_req = '0;
	end

	////////////////////////////////////////////////////////////////////
	// One request, held until the taking edge
	task automatic access(input logic [1:0] tbl, input logic [15:0] adr,
		input logic wr, input logic [15:0] wd, output logic [15:0] rd,
		output logic err, output logic seen);
		int n;
		n = 0;
		seen = 1'b0;
		rd = 'x;
		err = 1'b0;
		@(posedge i_clk);
		#1;
		o_req_valid = 1'b1;
		o_req = '{table_sel: tbl, addr: adr, write: wr, wdata: wd};
		@(posedge i_clk);
		#1;
		o_req_valid = 1'b0;
		// Released fields never keep their last value
		o_req = ~o_req;
		while (!seen && n < 4) begin
			if (i_rsp_valid === 1'b1) begin
				seen = 1'b1;
				rd = i_rsp_data;
				err = i_rsp_err;
			end else begin
				@(posedge i_clk);
				#1;
				n++;
			end
		end
	endtask

	task automatic clear_alarm(output logic err, output logic seen);
		logic [15:0] d;
		access(TBL_COIL, ADR_ALARM_CLR, 1'b1, 16'h0001, d, err, seen);
	endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench of the output register bank
`timescale 1ns/1ps
module testbench
	import dop_pkg::*;
;
	localparam int MSC = 4;
	// Arbitrary identity values
	localparam logic [31:0] NET = 32'h0A_14_1E_28;
	localparam logic [23:0] FWR = 24'h03_07_0B;
	localparam logic [16*LABEL_WORDS-1:0] LBL = {16'h4142,
		{(16*LABEL_WORDS-32){1'b0}}, 16'h5A59};

	logic           clk = 1'b0;
	logic           rstn = 1'b0;
	logic           req_valid;
	dop_req_t       req;
	logic           rsp_valid;
	logic [15:0]    rsp_data;
	logic           rsp_err;
	logic [NCH-1:0] peer = '0;
	logic [NCH-1:0] safe = '0;
	logic           trip = 1'b0;
	logic           ce = 1'b1;
	logic           alarm;
	logic [NCH-1:0] ch_out;
	int             n_mismatch = 0;
	int             compares = 0;
	int             n;

	always #4 clk = ~clk;

	dop_regs #(.MS_CYCLES(MSC), .NET_ADDR(NET), .FW_REL(FWR), .LABEL(LBL))
	DUT (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_CORE_CE(ce),
		.I_REQ_VALID(req_valid), .I_REQ(req), .O_RSP_VALID(rsp_valid),
		.O_RSP_DATA(rsp_data), .O_RSP_ERR(rsp_err), .I_PEER_LINK(peer),
		.I_SAFE_MODE(safe), .I_WDOG_TRIP(trip), .O_WDOG_ALARM(alarm),
		.O_CH_OUT(ch_out));

	dop_client cl (.i_clk(clk), .o_req_valid(req_valid), .o_req(req),
		.i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
		.i_rsp_err(rsp_err));

	////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask

	task automatic rd(input logic [1:0] t, input logic [15:0] a,
		input logic [15:0] e);
		logic [15:0] d;
		logic        er;
		logic        s;
		cl.access(t, a, 1'b0, 16'h0000, d, er, s);
		chk({s, er, d}, {2'b10, e});
	endtask

	task automatic wr(input logic [1:0] t, input logic [15:0] a,
		input logic [15:0] w, input logic ee);
		logic [15:0] d;
		logic        er;
		logic        s;
		cl.access(t, a, 1'b1, w, d, er, s);
		chk({16'h0000, s, er}, {16'h0000, 1'b1, ee});
	endtask

	task automatic span(input logic lvl, output int k);
		k = 0;
		while (ch_out[1] === lvl && k < 200) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		logic er;
		logic s;
		logic [15:0] u0;
		idle(2);
		rstn = 1'b1;
		chk({13'h0, alarm, ch_out}, 18'h0);
		rd(TBL_COIL, ADR_OUT_STATE, RST_WORD);
		rd(TBL_HOLD, ADR_HIGH_TIME + 16'h1, RST_TIME);
		rd(TBL_HOLD, ADR_LOW_TIME + 16'h3, RST_TIME);
		rd(TBL_HOLD, ADR_PULSE_CNT, RST_WORD);
		// Per-channel coils then packed word
		for (int c = 0; c < NCH; c++)
			wr(TBL_COIL, ADR_OUT_STATE + 16'(c), 16'(!c[0]), 1'b0);
		idle(2);
		chk({14'h0, ch_out}, 18'h5);
		rd(TBL_HOLD, ADR_PACKED_OUT, 16'h0005);
		wr(TBL_HOLD, ADR_PACKED_OUT, 16'h000A, 1'b0);
		idle(2);
		chk({14'h0, ch_out}, 18'hA);
		for (int c = 0; c < NCH; c++)
			rd(TBL_COIL, ADR_OUT_STATE + 16'(c), 16'(c[0]));
		// Let the last answer drop before freezing the enable
		idle(1);
		ce = 1'b0;
		cl.access(TBL_COIL, ADR_OUT_STATE, 1'b1, 16'h1, u0, er, s);
		chk({13'h0, s, ch_out}, 18'hA);
		ce = 1'b1;
		rd(TBL_COIL, ADR_OUT_STATE, 16'h0000);
		// Status pins
		peer = 4'h5;
		safe = 4'hA;
		idle(4);
		for (int c = 0; c < NCH; c++) begin
			rd(TBL_DISC, ADR_PEER_LINK + 16'(c), 16'(!c[0]));
			rd(TBL_DISC, ADR_SAFE_FLAG + 16'(c), 16'(c[0]));
		end
		// Refused writes and unmapped place
		wr(TBL_DISC, ADR_PEER_LINK, 16'h0000, 1'b1);
		wr(TBL_INPT, ADR_NET_ADDR, 16'h1234, 1'b1);
		rd(TBL_DISC, ADR_PEER_LINK, 16'h0001);
		cl.access(TBL_HOLD, 16'h0100, 1'b0, 16'h0, u0, er, s);
		chk({16'h0, s, er}, 18'h3);
		// Identity words
		rd(TBL_INPT, ADR_NET_ADDR, NET[31:16]);
		rd(TBL_INPT, ADR_NET_ADDR + 16'h1, NET[15:0]);
		rd(TBL_INPT, ADR_FW_REL, FWR[23:8]);
		rd(TBL_INPT, ADR_FW_REL + 16'h1, {FWR[7:0], 8'h00});
		rd(TBL_INPT, ADR_LABEL, 16'h4142);
		rd(TBL_INPT, ADR_LABEL + 16'h001D, 16'h5A59);
		// Pulse train on channel 1, two pulses
		wr(TBL_COIL, ADR_OUT_STATE + 16'h1, 16'h0000, 1'b0);
		wr(TBL_HOLD, ADR_HIGH_TIME + 16'h1, 16'h0002, 1'b0);
		wr(TBL_HOLD, ADR_LOW_TIME + 16'h1, 16'h0003, 1'b0);
		wr(TBL_HOLD, ADR_PULSE_CNT + 16'h1, 16'h0002, 1'b0);
		wr(TBL_COIL, ADR_PULSE_RUN + 16'h1, 16'h0001, 1'b0);
		span(1'b0, n);
		span(1'b1, n);
		chk(18'(n), 18'(2 * MSC));
		span(1'b0, n);
		chk(18'(n), 18'(3 * MSC));
		span(1'b1, n);
		chk(18'(n), 18'(2 * MSC));
		span(1'b0, n);
		chk(18'(n), 18'h000C8);
		rd(TBL_COIL, ADR_PULSE_RUN + 16'h1, 16'h0000);
		rd(TBL_HOLD, ADR_HIGH_TIME + 16'h1, 16'h0002);
		// Watchdog alarm set then cleared
		trip = 1'b1;
		idle(3);
		trip = 1'b0;
		idle(6);
		chk({17'h0, alarm}, 18'h1);
		rd(TBL_COIL, ADR_ALARM_CLR, 16'h0001);
		cl.clear_alarm(er, s);
		chk({16'h0, s, er}, 18'h2);
		idle(3);
		chk({17'h0, alarm}, 18'h0);
		rd(TBL_COIL, ADR_ALARM_CLR, 16'h0000);
		// Uptime advances once per thousand ticks
		cl.access(TBL_INPT, ADR_UPTIME + 16'h1, 1'b0, '0, u0, er, s);
		chk({16'h0, s, er}, 18'h2);
		idle(1000 * MSC - 2);
		rd(TBL_INPT, ADR_UPTIME + 16'h1, u0 + 16'h1);
		finish_test();
	end

	// Hang guard, well past the expected run length
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
endmodule
